/* hw/mafc_flow.sv */
// load/store multiple sequencer, call/return timing and return stack
`include "mafc_map.svh"

module mafc_flow import mafc_pkg::*; #(
	parameter int RAS_DEPTH = `MAFC_RAS_DEPTH
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic opValid,
	input wire mafc_op_t opKind,
	input wire logic isSwap,
	input wire logic [15:0] regList,
	input wire logic [31:0] baseAddr,
	input wire logic ptrUp,
	input wire logic writeBack,
	input wire logic predOk,
	input wire logic longForm,
	input wire logic [31:0] targetAddr,
	input wire logic [31:0] retAddr,
	input wire logic [31:0] retValue,
	input wire logic [31:0] memRdata,
	input wire logic [3:0] swapReg,
	input wire logic wrRegValid,
	input wire logic [3:0] wrReg,
	output logic opReady,
	output logic memValid,
	output logic memWrite,
	output logic [31:0] memAddr,
	output logic [3:0] memReg,
	output logic ptrReady,
	output logic [31:0] ptrValue,
	output logic dataReady,
	output logic flagValid,
	output logic flagZero,
	output logic flagNeg,
	output logic flush,
	output logic redirect,
	output logic [31:0] redirectAddr,
	output logic linkWrite,
	output logic hazard,
	output logic [2:0] rasCount
);
	function automatic logic [3:0] pickReg(input logic [15:0] m, input logic low);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 15; i >= 0; i--) if (low && m[i]) r = 4'(i);
		for (int i = 0; i < 16; i++) if (!low && m[i]) r = 4'(i);
		return r;
	endfunction
	function automatic logic [31:0] popCount(input logic [15:0] m);
		logic [31:0] n;
		n = 32'h0;
		for (int i = 0; i < 16; i++) n = n + {31'h0, m[i]};
		return n;
	endfunction

	// ==========================================
	// decode
	mafc_state_t state, next_state;
	logic [15:0] mask, next_mask, storeMask, next_storeMask;
	logic [31:0] addr, next_addr, ras [RAS_DEPTH];
	logic up, pcWait;
	logic [2:0] cnt, next_cnt, penCnt, resCnt, flagCnt;
	wire accept = opValid && opReady;
	wire isLoadM = opKind inside {OP_LOAD_MULTI, OP_LOAD_MULTI_TS, OP_CTX_POP, OP_POP_MULTI};
	wire isStoreM = opKind inside {OP_CTX_PUSH, OP_PUSH_MULTI, OP_STORE_MULTI};
	wire isMulti = !isSwap && (isLoadM || isStoreM);
	wire isCall = !isSwap && opKind inside {OP_CALL_REL, OP_CALL_MEM, OP_CALL_APP,
		OP_CALL_REG, OP_CALL_SUP};
	wire isMemCall = !isSwap && opKind inside {OP_CALL_MEM, OP_CALL_APP};
	wire pcLoad = isMulti && isLoadM && regList[15];
	wire rasEmpty = rasCount == 3'h0;
	wire pcFlush = pcLoad && rasEmpty;
	wire retHit = !isSwap && opKind == OP_RET && predOk && !rasEmpty;
	wire pop = accept && (retHit || (pcLoad && !rasEmpty));
	wire push = accept && isCall;
	wire [2:0] predLat = longForm ? `MAFC_PRED_LONG : `MAFC_PRED_SHORT;
	wire [31:0] nWords = popCount(regList) << 2;
	wire [31:0] startAddr = ptrUp ? baseAddr : baseAddr - `MAFC_WORD_STEP;
	wire multiDone = state == ST_MULTI && mask == 16'h0 && penCnt == 3'h0;
	wire emit = (accept && isMulti) || (state == ST_MULTI && mask != 16'h0);
	wire [15:0] srcMask = accept ? regList : mask;
	wire [31:0] srcAddr = accept ? startAddr : addr;
	wire srcUp = accept ? ptrUp : up;
	wire [3:0] emitReg = pickReg(srcMask, srcUp);
	wire [15:0] emitBit = 16'h1 << emitReg;
	wire [15:0] doneBit = (memValid && memWrite) ? 16'h1 << memReg : 16'h0;
	logic [2:0] lat;

	// ==========================================
	// issue latency per class
	always_comb begin
		lat = `MAFC_PRED_SHORT;
		if (isSwap) begin
			lat = `MAFC_SWAP_ISSUE;
		end else begin
			unique case (opKind)
				OP_JUMP: lat = predLat;
				OP_BRANCH, OP_CALL_REL: lat = predOk ? predLat : `MAFC_MISPRED_LAT;
				OP_RET: lat = retHit ? predLat : `MAFC_MISPRED_LAT;
				OP_CALL_MEM, OP_CALL_APP: lat = `MAFC_MEMCALL_LAT;
				OP_CALL_REG, OP_CALL_SUP: lat = `MAFC_INDCALL_LAT;
				OP_RET_EXC: lat = `MAFC_RETX_LAT;
				default: lat = `MAFC_PRED_SHORT;
			endcase
		end
	end

	// ==========================================
	// sequencer
	always_comb begin
		next_state = state;
		next_mask = mask;
		next_addr = addr;
		next_cnt = cnt;
		if (emit) begin
			next_mask = srcMask & ~emitBit;
			next_addr = srcUp ? srcAddr + `MAFC_WORD_STEP : srcAddr - `MAFC_WORD_STEP;
		end
		unique case (state)
			ST_IDLE: if (accept) begin
				if (isMulti) next_state = ST_MULTI;
				else if (isSwap) next_state = ST_SWAP_WR;
				else if (lat != `MAFC_PRED_SHORT) next_state = ST_WAIT;
				next_cnt = lat - 3'h1;
			end
			ST_MULTI: if (multiDone) next_state = ST_IDLE;
			ST_SWAP_WR: next_state = ST_IDLE;
			ST_WAIT: begin
				next_cnt = cnt - 3'h1;
				if (cnt == 3'h1) next_state = ST_IDLE;
			end
		endcase
		next_storeMask = storeMask & ~doneBit;
		if (accept && isMulti && isStoreM) next_storeMask = regList;
		if (accept && isSwap) next_storeMask = 16'h1 << swapReg;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			mask <= 16'h0;
			storeMask <= 16'h0;
			addr <= 32'h0;
			up <= 1'b1;
			cnt <= 3'h0;
			hazard <= 1'b0;
		end else begin
			state <= next_state;
			mask <= next_mask;
			storeMask <= next_storeMask;
			addr <= next_addr;
			cnt <= next_cnt;
			if (accept) up <= ptrUp;
			hazard <= wrRegValid && next_storeMask[wrReg];
		end
	end

	// ==========================================
	// ready, memory side and pointer
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			opReady <= 1'b1;
			memValid <= 1'b0;
			memWrite <= 1'b0;
			memAddr <= 32'h0;
			memReg <= 4'h0;
			ptrReady <= 1'b0;
			ptrValue <= 32'h0;
		end else begin
			opReady <= next_state == ST_IDLE;
			memValid <= emit || (accept && (isSwap || isMemCall)) || state == ST_SWAP_WR;
			memWrite <= emit ? (accept ? isStoreM : !pcWait && storeMask != 16'h0)
				: state == ST_SWAP_WR;
			memAddr <= emit ? srcAddr : (accept ? targetAddr : memAddr);
			memReg <= emit ? emitReg : (accept && isMemCall ? `MAFC_PC_REG
				: (accept ? swapReg : memReg));
			ptrReady <= accept && isMulti && writeBack;
			if (accept && isMulti)
				ptrValue <= ptrUp ? baseAddr + nWords : baseAddr - nWords;
		end
	end

	// ==========================================
	// flush, result and flag timing
	logic [31:0] pcData;
	logic memFlow;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			penCnt <= 3'h0;
			resCnt <= 3'h0;
			flagCnt <= 3'h0;
			flush <= 1'b0;
			dataReady <= 1'b0;
			flagValid <= 1'b0;
			flagZero <= 1'b0;
			flagNeg <= 1'b0;
			pcWait <= 1'b0;
			pcData <= 32'h0;
			memFlow <= 1'b0;
		end else begin
			flush <= accept && pcFlush;
			if (accept && pcFlush) penCnt <= `MAFC_PC_PENALTY;
			else if (penCnt != 3'h0) penCnt <= penCnt - 3'h1;
			if (accept && isMulti && isLoadM) resCnt <= `MAFC_FIRST_LAT - 3'h1;
			else if (accept && isSwap) resCnt <= `MAFC_SWAP_RESULT - 3'h1;
			else if (resCnt != 3'h0) resCnt <= resCnt - 3'h1;
			dataReady <= resCnt == 3'h1;
			if (accept && pcLoad) begin
				flagCnt <= `MAFC_FLAG_LAT - 3'h1;
				flagZero <= retValue == 32'h0;
				flagNeg <= retValue[31];
			end else if (flagCnt != 3'h0) begin
				flagCnt <= flagCnt - 3'h1;
			end
			flagValid <= flagCnt == 3'h1;
			if (accept) memFlow <= isMemCall || pcFlush;
			pcWait <= memValid && !memWrite && memReg == `MAFC_PC_REG;
			if (pcWait) pcData <= memRdata;
		end
	end

	// ==========================================
	// return stack and redirect
	// a pc read by the last access of a list lands one cycle after the list ends
	logic pcGot, lateWait;
	wire listEnd = memFlow && multiDone;
	wire late = (listEnd && (pcGot || pcWait)) || (lateWait && pcWait)
		|| (memFlow && state == ST_WAIT && cnt == 3'h1);
	wire [2:0] next_rasCount = push ? (rasCount == 3'(RAS_DEPTH) ? rasCount : rasCount + 3'h1)
		: (pop ? rasCount - 3'h1 : rasCount);
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rasCount <= 3'h0;
			linkWrite <= 1'b0;
			redirect <= 1'b0;
			redirectAddr <= 32'h0;
			pcGot <= 1'b0;
			lateWait <= 1'b0;
		end else begin
			rasCount <= next_rasCount;
			pcGot <= !accept && (pcGot || pcWait);
			lateWait <= listEnd && !pcGot && !pcWait;
			linkWrite <= push;
			redirect <= late || pop || (accept && !isMulti && !isSwap && !isMemCall
				&& (opKind == OP_RET_EXC || opKind inside {OP_CALL_REG, OP_CALL_SUP}
				|| (opKind == OP_RET && !retHit)
				|| (opKind inside {OP_BRANCH, OP_CALL_REL} && !predOk)));
			if (late) redirectAddr <= late && pcWait ? memRdata : pcData;
			else if (pop) redirectAddr <= ras[0];
			else if (accept) redirectAddr <= targetAddr;
		end
	end
	// entry 0 is the top; pushing past full drops the deepest entry
	for (genvar g = 0; g < RAS_DEPTH; g++) begin : g_ras
		always_ff @(posedge clk or negedge nrst) begin
			if (!nrst) ras[g] <= 32'h0;
			else if (push) ras[g] <= (g == 0) ? retAddr : ras[g == 0 ? 0 : g - 1];
			else if (pop) ras[g] <= (g == RAS_DEPTH - 1) ? 32'h0 : ras[g == RAS_DEPTH - 1 ? g : g + 1];
		end
	end

	// ==========================================
	// checks
	sequence s_swapRd;
		memValid && !memWrite;
	endsequence
	sequence s_swapWr;
		memValid && memWrite;
	endsequence
	property p_ptr;
		@(posedge clk) disable iff (!nrst) accept && isMulti && writeBack |=> ptrReady;
	endproperty
	a_ptr: assert property (p_ptr) else $error("pointer not ready after one cycle");
	property p_first;
		@(posedge clk) disable iff (!nrst) accept && isMulti && isLoadM |-> ##2 dataReady;
	endproperty
	a_first: assert property (p_first) else $error("first load data late");
	property p_flag;
		@(posedge clk) disable iff (!nrst) accept && pcLoad |-> !flagValid ##2 flagValid;
	endproperty
	a_flag: assert property (p_flag) else $error("flag latency wrong");
	property p_flush;
		@(posedge clk) disable iff (!nrst) accept && pcFlush |=> flush ##0 !opReady[*6];
	endproperty
	a_flush: assert property (p_flush) else $error("flush penalty short");
	property p_ras;
		@(posedge clk) disable iff (!nrst) push && rasCount == 3'h4 |=> rasCount == 3'h4;
	endproperty
	a_ras: assert property (p_ras) else $error("full stack grew");
	property p_link;
		@(posedge clk) disable iff (!nrst) accept && isCall |=> linkWrite;
	endproperty
	a_link: assert property (p_link) else $error("call without link write");
	property p_swap;
		@(posedge clk) disable iff (!nrst)
			accept && isSwap |=> s_swapRd ##1 s_swapWr ##0 opReady ##1 dataReady;
	endproperty
	a_swap: assert property (p_swap) else $error("swap sequence wrong");
	property p_miss;
		@(posedge clk) disable iff (!nrst)
			accept && !isSwap && opKind == OP_CALL_REL && !predOk |=> !opReady[*3] ##1 opReady;
	endproperty
	a_miss: assert property (p_miss) else $error("mispredicted call not four");
	property p_memcall;
		@(posedge clk) disable iff (!nrst) accept && isMemCall |=> !opReady[*5] ##1 opReady;
	endproperty
	a_memcall: assert property (p_memcall) else $error("memory call not six");
	property p_retx;
		@(posedge clk) disable iff (!nrst) accept && !isSwap && opKind == OP_RET_EXC
			|=> redirect && redirectAddr == $past(targetAddr);
	endproperty
	a_retx: assert property (p_retx) else $error("return target not fetched");
	property p_haz;
		@(posedge clk) disable iff (!nrst) accept && wrRegValid
			&& ((isMulti && isStoreM && regList[wrReg]) || (isSwap && wrReg == swapReg)) |=> hazard;
	endproperty
	a_haz: assert property (p_haz) else $error("store hazard missed");
	property p_jump;
		@(posedge clk) disable iff (!nrst)
			accept && !isSwap && opKind == OP_JUMP && !longForm |=> opReady && !redirect;
	endproperty
	a_jump: assert property (p_jump) else $error("jump treated as miss");
endmodule

/* shared/mafc_map.svh */
// cycle counts and fixed positions for the flow-change timing block
`ifndef MAFC_MAP_SVH
`define MAFC_MAP_SVH
`define MAFC_RAS_DEPTH 4
`define MAFC_PC_REG 4'hF
`define MAFC_WORD_STEP 32'h4
`define MAFC_PTR_LAT 1
`define MAFC_FIRST_LAT 3'h2
`define MAFC_FLAG_LAT 3'h2
`define MAFC_PC_PENALTY 3'h6
`define MAFC_PRED_SHORT 3'h1
`define MAFC_PRED_LONG 3'h2
`define MAFC_MISPRED_LAT 3'h4
`define MAFC_MEMCALL_LAT 3'h6
`define MAFC_INDCALL_LAT 3'h4
`define MAFC_RETX_LAT 3'h4
`define MAFC_SWAP_ISSUE 3'h2
`define MAFC_SWAP_RESULT 3'h3
`endif

/* shared/mafc_pkg.sv */
// types for the flow-change timing block
package mafc_pkg;
	typedef enum logic [3:0] {
		OP_LOAD_MULTI, OP_LOAD_MULTI_TS, OP_CTX_POP, OP_POP_MULTI,
		OP_CTX_PUSH, OP_PUSH_MULTI, OP_STORE_MULTI, OP_JUMP,
		OP_BRANCH, OP_RET, OP_CALL_REL, OP_CALL_MEM,
		OP_CALL_APP, OP_CALL_REG, OP_CALL_SUP, OP_RET_EXC
	} mafc_op_t;
	typedef enum logic [2:0] {ST_IDLE, ST_MULTI, ST_WAIT, ST_SWAP_WR} mafc_state_t;
endpackage

/* tb/mafc_mem_model.sv */
// data memory partner answering the access stream of the flow block
module mafc_mem_model (
	input wire logic clk,
	input wire logic nrst,
	input wire logic memValid,
	input wire logic memWrite,
	input wire logic [31:0] memAddr,
	output logic [31:0] memRdata
);
	timeunit 1ns;
	timeprecision 1ps;
	// =========================================
	// read data
	// read word follows its address one cycle later, else inverted so stale use shows
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			memRdata <= 32'h0;
		end else if (memValid && !memWrite) begin
			memRdata <= memAddr ^ 32'h5A5A0000;
		end else begin
			memRdata <= ~memRdata;
		end
	end
endmodule

/* tb/tb_top.sv */
// self-checking bench for the flow-change timing block
module tb_top import mafc_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct {mafc_op_t op; logic pred; logic lng; int lat; logic link;} mafc_row_t;
	logic clk, nrst, opValid, isSwap, ptrUp, writeBack, predOk, longForm, wrRegValid;
	mafc_op_t opKind;
	logic [15:0] regList;
	logic [31:0] baseAddr, targetAddr, retAddr, retValue, memRdata, memAddr, ptrValue, redirectAddr;
	logic [3:0] swapReg, wrReg, memReg;
	logic opReady, memValid, memWrite, ptrReady, dataReady, flagValid, flagZero, flagNeg;
	logic flush, redirect, linkWrite, hazard;
	logic [2:0] rasCount;
	logic [31:0] mv, mw, pr, dr, fv, fl, lw, hz, rd;
	logic [31:0] addr [32];
	logic [3:0] mreg [32];
	int lat, latB, checks, mismatches;
	mafc_row_t rows [9] = '{'{OP_JUMP, 1'b0, 1'b0, 1, 1'b0}, '{OP_BRANCH, 1'b1, 1'b1, 2, 1'b0},
		'{OP_CALL_REL, 1'b1, 1'b0, 1, 1'b1}, '{OP_CALL_REL, 1'b1, 1'b1, 2, 1'b1},
		'{OP_CALL_REL, 1'b0, 1'b0, 4, 1'b1}, '{OP_CALL_APP, 1'b0, 1'b0, 6, 1'b1},
		'{OP_CALL_REG, 1'b0, 1'b0, 4, 1'b1}, '{OP_CALL_SUP, 1'b0, 1'b0, 4, 1'b1},
		'{OP_CALL_MEM, 1'b0, 1'b0, 6, 1'b1}};

	mafc_flow dut (.clk(clk), .nrst(nrst), .opValid(opValid), .opKind(opKind), .isSwap(isSwap),
		.regList(regList), .baseAddr(baseAddr), .ptrUp(ptrUp), .writeBack(writeBack),
		.predOk(predOk), .longForm(longForm), .targetAddr(targetAddr), .retAddr(retAddr),
		.retValue(retValue), .memRdata(memRdata), .swapReg(swapReg), .wrRegValid(wrRegValid),
		.wrReg(wrReg), .opReady(opReady), .memValid(memValid), .memWrite(memWrite),
		.memAddr(memAddr), .memReg(memReg), .ptrReady(ptrReady), .ptrValue(ptrValue),
		.dataReady(dataReady), .flagValid(flagValid), .flagZero(flagZero), .flagNeg(flagNeg),
		.flush(flush), .redirect(redirect), .redirectAddr(redirectAddr),
		.linkWrite(linkWrite), .hazard(hazard), .rasCount(rasCount));
	mafc_mem_model mem (.clk(clk), .nrst(nrst), .memValid(memValid), .memWrite(memWrite),
		.memAddr(memAddr), .memRdata(memRdata));

	// =========================================
	// clock, watchdog, helpers
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		close_out();
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	// offers one instruction at a falling edge, records each cycle after the accept until two cycles past ready
	task automatic run_op(input mafc_op_t k, input logic [15:0] rl);
		lat = 0;
		{mv, mw, pr, dr, fv, fl, lw, hz, rd} = '0;
		opKind = k;
		regList = rl;
		opValid = 1'b1;
		@(negedge clk);
		opValid = 1'b0;
		for (int n = 1; n < 31; n++) begin
			{mv[n], mw[n], pr[n], dr[n], fv[n], fl[n], lw[n], hz[n]} = {memValid, memWrite,
				ptrReady, dataReady, flagValid, flush, linkWrite, hazard};
			addr[n] = memAddr;
			mreg[n] = memReg;
			rd[n] = redirect;
			if (lat == 0 && opReady === 1'b1) lat = n;
			if (lat != 0 && n >= lat + 2) break;
			@(negedge clk);
		end
	endtask

	// =========================================
	// main sequence
	initial begin
		{nrst, opValid, isSwap, ptrUp, writeBack, predOk, longForm, wrRegValid} = '0;
		opKind = OP_JUMP;
		{regList, swapReg, wrReg} = '0;
		{baseAddr, retAddr, retValue} = '0;
		targetAddr = 32'h00006000;
		repeat (20) @(negedge clk);
		chk({opReady, memValid, flush, rasCount}, 6'h20);
		nrst = 1'b1;
		@(negedge clk);
		foreach (rows[i]) begin
			predOk = rows[i].pred;
			longForm = rows[i].lng;
			run_op(rows[i].op, 16'h0);
			chk(lat, rows[i].lat);
			chk(lw != 0, rows[i].link);
		end
		chk(redirectAddr, 32'h5A5A6000);
		run_op(OP_RET_EXC, 16'h0);
		chk({lat[3:0], lw[3:0]}, 8'h40);
		chk(rd[3:0], 4'h2);
		$display("test flow latencies done");
		{predOk, longForm} = 2'b10;
		for (int i = 1; i < 6; i++) begin
			retAddr = 32'h1000 + i;
			run_op(OP_CALL_REL, 16'h0);
		end
		chk(rasCount, 3'h4);
		for (int i = 5; i > 1; i--) begin
			run_op(OP_RET, 16'h0);
			chk({redirectAddr[15:0], lat[3:0]}, {16'h1000 + i[15:0], 4'h1});
		end
		run_op(OP_RET, 16'h0);
		chk({lat[3:0], 1'b0, rasCount}, 8'h40);
		$display("test return stack done");
		{baseAddr, ptrUp, writeBack} = {32'h2000, 2'b11};
		run_op(OP_LOAD_MULTI, 16'h0003);
		chk({addr[1][15:0], addr[2][15:0]}, 32'h20002004);
		chk({mreg[1], mreg[2], mv[7:0], pr[7:0], dr[7:0]}, 32'h01060204);
		chk({ptrValue[15:0], fv[7:0], fl[7:0]}, 32'h20080000);
		$display("test load multiple done");
		{baseAddr, ptrUp, wrRegValid, wrReg} = {32'h3000, 2'b01, 4'h4};
		run_op(OP_STORE_MULTI, 16'h0070);
		chk({addr[1][15:0], addr[3][15:0]}, 32'h2FFC2FF4);
		chk({mreg[1], mreg[3], mv[7:0], mw[7:0], ptrValue[7:0]}, 32'h640E0EF4);
		chk(hz != 0, 1'b1);
		wrReg = 4'h7;
		run_op(OP_STORE_MULTI, 16'h0070);
		chk(hz, 32'h0);
		$display("test store multiple done");
		{isSwap, targetAddr, swapReg, wrReg} = {1'b1, 32'h5000, 4'h5, 4'h5};
		run_op(OP_JUMP, 16'h0);
		chk({lat[3:0], mv[3:0], mw[3:0], dr[3:0]}, 16'h2648);
		chk({addr[1][15:0], addr[2][15:0]}, 32'h50005000);
		chk(hz != 0, 1'b1);
		{isSwap, wrRegValid} = 2'b00;
		$display("test swap done");
		{baseAddr, ptrUp, writeBack, retValue} = {32'h4000, 2'b10, 32'h0};
		run_op(OP_LOAD_MULTI, 16'h8001);
		chk({fl[3:0], fv[3:0], 3'h0, flagZero, 3'h0, flagNeg}, 16'h2410);
		chk(redirectAddr, 32'h5A5A4004);
		chk(rd, 32'h00000100);
		retValue = 32'h80000000;
		run_op(OP_POP_MULTI, 16'h7FFF);
		latB = lat;
		run_op(OP_POP_MULTI, 16'hFFFF);
		chk(lat, latB + 1);
		chk({flagZero, flagNeg}, 2'b01);
		chk(redirectAddr, 32'h5A5A403C);
		chk(rd, 32'h00040000);
		$display("test pc load done");
		opKind = OP_STORE_MULTI;
		{regList, wrRegValid, wrReg} = {16'h00F0, 1'b1, 4'h7};
		opValid = 1'b1;
		@(negedge clk);
		{opValid, nrst} = 2'b00;
		@(negedge clk);
		chk({opReady, memValid, memWrite, hazard, rasCount}, 7'h40);
		nrst = 1'b1;
		@(negedge clk);
		run_op(OP_JUMP, 16'h0);
		chk({lat[3:0], hz[3:0]}, 8'h10);
		wrRegValid = 1'b0;
		$display("test mid-run reset done");
		close_out();
	end
endmodule
